// ==== wrs_defs.svh ====
// Purpose: constants of the watchdog and power-on-clear reset sequencer
// Assumes: included by its bare name from the package and the modules
// Notes:   times are in their own unit; the watchdog-2 hold cycle count derives from the clock period
`ifndef WRS_DEFS_SVH
`define WRS_DEFS_SVH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define WRS_CLK_PERIOD_NS 5

// ----------------------------------------------------------------------------
// reset hold lengths
// ----------------------------------------------------------------------------
`define WRS_WDOG1_HOLD_CYC 12
`define WRS_WDOG2_HOLD_NS 20
`define WRS_WDOG2_HOLD_CYC ((`WRS_WDOG2_HOLD_NS + `WRS_CLK_PERIOD_NS - 1) / `WRS_CLK_PERIOD_NS)
`define WRS_HOLD_W 8

// ----------------------------------------------------------------------------
// oscillation settle wait: cycles = 2 ** (base + select code)
// ----------------------------------------------------------------------------
`define WRS_SETTLE_BASE_LOG2 13
`define WRS_SETTLE_SEL_DEFAULT 3
`define WRS_SETTLE_SEL_W 3
`define WRS_CNT_W 24

`endif

// ==== wrs_pkg.sv ====
// Purpose: types of the watchdog and power-on-clear reset sequencer
// Assumes: wrs_defs.svh gives the widths
// Notes:   state and carrier signals are packed structs; the cause and state codes are enums
`include "wrs_defs.svh"

package wrs_pkg;

    typedef enum logic [1:0] {
        CAUSE_POC,
        CAUSE_WDOG1,
        CAUSE_WDOG2
    } wrs_cause_t;

    typedef enum logic [2:0] {
        ST_POC,
        ST_HOLD1,
        ST_HOLD2,
        ST_SETTLE,
        ST_RUN
    } wrs_state_t;

    typedef struct packed {
        logic main_osc_en;
        logic int_osc_en;
        logic sub_osc_en;
        logic wdog1_clk_en;
        logic periph_clk_en;
        logic sys_clk_en;
        logic cpu_clk_en;
        logic clkdiv_init;
        logic wdog2_run;
    } wrs_clk_ctl_t;

    typedef struct packed {
        logic port0_bit0;
        logic port0_bit0_oe;
        logic port_hiz;
    } wrs_pin_ctl_t;

    typedef struct packed {
        wrs_state_t                 state;
        logic [`WRS_HOLD_W-1:0]     hold_cnt;
        wrs_cause_t                 cause;
        wrs_clk_ctl_t               clk;
        wrs_pin_ctl_t               pin;
        logic                       sys_reset_n;
        logic                       cpu_run;
        logic                       ram_undef;
        logic                       settle_load;
        logic                       poc_meta;
        logic                       poc_sync;
    } wrs_core_t;

endpackage

// ==== wrs_settle_timer.sv ====
// Purpose: one-shot down counter timing the oscillation settle wait
// Assumes: load_i is a one-cycle pulse from logic on core_clk_i
// Notes:   done_o pulses for one cycle, load_val_i cycles after the load edge
`timescale 1ns/1ps
`default_nettype none
`include "wrs_defs.svh"

module wrs_settle_timer #(
    parameter int CNT_W = `WRS_CNT_W
) (
    input  wire logic             core_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_val_i,
    output logic                  busy_o,
    output logic                  done_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             busy;
        logic             done;
    } wrs_tmr_t;

    wrs_tmr_t r_reg;
    wrs_tmr_t r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        if (load_i) begin
            r_next.cnt  = load_val_i;
            r_next.busy = (load_val_i != '0);
        end else if (r_reg.busy) begin
            r_next.cnt = r_reg.cnt - 1'b1;
            if (r_reg.cnt == CNT_W'(1)) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign busy_o = r_reg.busy;
    assign done_o = r_reg.done;

endmodule
`default_nettype wire

// ==== wrs_reset_seq.sv ====
// Purpose: system reset sequencer for watchdog-1, watchdog-2 and power-on-clear
// Assumes: watchdog requests come from logic on core_clk_i; the power-on-clear
//          level comes from an analog detector and is synchronised here
// Notes:   clock and oscillator controls are enables for the clock generator;
//          this block itself keeps running on core_clk_i throughout
`timescale 1ns/1ps
`default_nettype none
`include "wrs_defs.svh"

module wrs_reset_seq
    import wrs_pkg::*;
#(
    parameter int SETTLE_BASE_LOG2   = `WRS_SETTLE_BASE_LOG2,
    parameter int OSC_SETTLE_DEFAULT = `WRS_SETTLE_SEL_DEFAULT,
    parameter int CNT_W              = `WRS_CNT_W
) (
    input  wire logic  core_clk_i,
    input  wire logic  rstn_i,
    input  wire logic  wdog1_mode_i,
    input  wire logic  wdog1_overflow_reset_i,
    input  wire logic  wdog2_mode_i,
    input  wire logic  wdog2_overflow_reset_i,
    input  wire logic  power_on_clear_reset_i,
    input  wire logic  ram_write_i,
    output logic       sys_reset_n_o,
    output logic       cpu_run_o,
    output wrs_cause_t reset_cause_o,
    output logic       ram_undef_o,
    output wrs_clk_ctl_t clk_ctl_o,
    output wrs_pin_ctl_t pin_ctl_o
);

    // ------------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------------
    localparam logic [`WRS_HOLD_W-1:0] WDOG1_LAST = `WRS_HOLD_W'(`WRS_WDOG1_HOLD_CYC - 1);
    localparam logic [`WRS_HOLD_W-1:0] WDOG2_LAST = `WRS_HOLD_W'(`WRS_WDOG2_HOLD_CYC - 1);
    localparam logic [`WRS_SETTLE_SEL_W-1:0] SETTLE_SEL =
        `WRS_SETTLE_SEL_W'(OSC_SETTLE_DEFAULT);

    localparam wrs_core_t CORE_RST = '{
        state:       ST_POC,
        hold_cnt:    '0,
        cause:       CAUSE_POC,
        clk:         '{sub_osc_en: 1'b1, clkdiv_init: 1'b1, default: 1'b0},
        pin:         '{port0_bit0: 1'b0, port0_bit0_oe: 1'b1, port_hiz: 1'b1},
        sys_reset_n: 1'b0,
        cpu_run:     1'b0,
        ram_undef:   1'b1,
        settle_load: 1'b0,
        poc_meta:    1'b0,
        poc_sync:    1'b0
    };

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    // settle wait length from a select code
    function automatic logic [CNT_W-1:0] settle_cycles(
        input logic [`WRS_SETTLE_SEL_W-1:0] sel
    );
        int sh;
        sh = SETTLE_BASE_LOG2 + int'(sel);
        settle_cycles = CNT_W'(1) << sh;
    endfunction

    // clock and oscillator enables per sequencer state
    function automatic wrs_clk_ctl_t clk_for(input wrs_state_t st);
        wrs_clk_ctl_t c;
        c            = '0;
        c.sub_osc_en = 1'b1;
        case (st)
            ST_HOLD1: begin
                c.main_osc_en  = 1'b1;
                c.int_osc_en   = 1'b1;
                c.wdog1_clk_en = 1'b1;
                c.sys_clk_en   = 1'b1;
                c.cpu_clk_en   = 1'b1;
                c.clkdiv_init  = 1'b1;
            end
            ST_HOLD2, ST_POC: begin
                c.clkdiv_init  = 1'b1;
            end
            ST_SETTLE: begin
                c.main_osc_en  = 1'b1;
                c.int_osc_en   = 1'b1;
                c.wdog1_clk_en = 1'b1;
                c.wdog2_run    = 1'b1;
            end
            ST_RUN: begin
                c.main_osc_en   = 1'b1;
                c.int_osc_en    = 1'b1;
                c.wdog1_clk_en  = 1'b1;
                c.periph_clk_en = 1'b1;
                c.sys_clk_en    = 1'b1;
                c.cpu_clk_en    = 1'b1;
                c.wdog2_run     = 1'b1;
            end
            default: begin
                c.clkdiv_init = 1'b1;
            end
        endcase
        clk_for = c;
    endfunction

    // true while the system is held in reset
    function automatic logic in_reset(input wrs_state_t st);
        in_reset = (st == ST_HOLD1) || (st == ST_HOLD2) || (st == ST_POC);
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    wrs_core_t r_reg;
    wrs_core_t r_next;
    logic      settle_done;
    logic      wd1_take;
    logic      wd2_take;

    wrs_settle_timer #(
        .CNT_W      (CNT_W)
    ) u_settle (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .load_i     (r_reg.settle_load),
        .load_val_i (settle_cycles(SETTLE_SEL)),
        .busy_o     (),
        .done_o     (settle_done)
    );

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        r_next             = r_reg;
        r_next.poc_meta    = power_on_clear_reset_i;
        r_next.poc_sync    = r_reg.poc_meta;
        r_next.settle_load = 1'b0;

        wd2_take = wdog2_mode_i && wdog2_overflow_reset_i &&
                   ((r_reg.state == ST_RUN) || (r_reg.state == ST_SETTLE));
        wd1_take = wdog1_mode_i && wdog1_overflow_reset_i && (r_reg.state == ST_RUN);

        case (r_reg.state)
            ST_POC: begin
                if (!r_reg.poc_sync) begin
                    r_next.state       = ST_SETTLE;
                    r_next.settle_load = 1'b1;
                end
            end
            ST_HOLD1: begin
                if (r_reg.hold_cnt == '0) begin
                    r_next.state = ST_RUN;
                end else begin
                    r_next.hold_cnt = r_reg.hold_cnt - 1'b1;
                end
            end
            ST_HOLD2: begin
                if (r_reg.hold_cnt == '0) begin
                    r_next.state       = ST_SETTLE;
                    r_next.settle_load = 1'b1;
                end else begin
                    r_next.hold_cnt = r_reg.hold_cnt - 1'b1;
                end
            end
            ST_SETTLE: begin
                // a done left over from a cancelled wait is ignored
                if (settle_done && !r_reg.settle_load) begin
                    r_next.state = ST_RUN;
                end
            end
            ST_RUN: begin
                r_next.state = ST_RUN;
            end
            default: begin
                r_next.state = ST_POC;
            end
        endcase

        // request priority: power-on-clear, then watchdog-2, then watchdog-1
        if (r_reg.poc_sync) begin
            r_next.state     = ST_POC;
            r_next.cause     = CAUSE_POC;
            r_next.ram_undef = 1'b1;
        end else if (wd2_take) begin
            r_next.state     = ST_HOLD2;
            r_next.hold_cnt  = WDOG2_LAST;
            r_next.cause     = CAUSE_WDOG2;
            r_next.ram_undef = ram_write_i;
        end else if (wd1_take) begin
            r_next.state     = ST_HOLD1;
            r_next.hold_cnt  = WDOG1_LAST;
            r_next.cause     = CAUSE_WDOG1;
            r_next.ram_undef = ram_write_i;
        end

        r_next.clk                = clk_for(r_next.state);
        r_next.sys_reset_n        = !in_reset(r_next.state);
        r_next.cpu_run            = (r_next.state == ST_RUN);
        r_next.pin.port0_bit0     = 1'b0;
        r_next.pin.port0_bit0_oe  = in_reset(r_next.state);
        r_next.pin.port_hiz       = in_reset(r_next.state);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_reg <= CORE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign sys_reset_n_o = r_reg.sys_reset_n;
    assign cpu_run_o     = r_reg.cpu_run;
    assign reset_cause_o = r_reg.cause;
    assign ram_undef_o   = r_reg.ram_undef;
    assign clk_ctl_o     = r_reg.clk;
    assign pin_ctl_o     = r_reg.pin;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    logic wd1_clean;
    assign wd1_clean = wd1_take && !r_reg.poc_sync && !wd2_take;

    // cycles in a row with system reset low, so a long hold needs no long repetition
    logic [7:0] low_cnt_reg;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_cnt_reg <= 8'h00;
        end else begin
            low_cnt_reg <= sys_reset_n_o ? 8'h00 : low_cnt_reg + 8'h01;
        end
    end

    sequence s_wd1_held;
        ##11 (!sys_reset_n_o && low_cnt_reg == 8'h0b);
    endsequence

    sequence s_released_running;
        sys_reset_n_o && cpu_run_o;
    endsequence

    property p_wd1_hold;
        wd1_clean && !r_reg.poc_meta |=> s_wd1_held ##1 s_released_running;
    endproperty
    a_wd1_hold: assert property (p_wd1_hold)
        else $error("watchdog-1 reset not held for 12 cycles");

    property p_wd1_enter;
        wd1_clean |=> !sys_reset_n_o && reset_cause_o == CAUSE_WDOG1;
    endproperty
    a_wd1_enter: assert property (p_wd1_enter)
        else $error("watchdog-1 overflow did not assert reset");

    property p_wd1_clocks;
        !sys_reset_n_o && reset_cause_o == CAUSE_WDOG1 |->
            clk_ctl_o.main_osc_en && clk_ctl_o.sys_clk_en && clk_ctl_o.cpu_clk_en &&
            clk_ctl_o.clkdiv_init && !clk_ctl_o.periph_clk_en && !clk_ctl_o.wdog2_run;
    endproperty
    a_wd1_clocks: assert property (p_wd1_clocks)
        else $error("wrong clock state in watchdog-1 reset");

    property p_wd1_no_wait;
        $rose(sys_reset_n_o) && reset_cause_o == CAUSE_WDOG1 |-> cpu_run_o;
    endproperty
    a_wd1_no_wait: assert property (p_wd1_no_wait)
        else $error("settle wait inserted after watchdog-1 reset");

    property p_pins;
        !sys_reset_n_o |-> pin_ctl_o.port0_bit0_oe && !pin_ctl_o.port0_bit0 &&
            pin_ctl_o.port_hiz;
    endproperty
    a_pins: assert property (p_pins)
        else $error("port pins not in reset state");

    property p_wd2_hold;
        wd2_take && !r_reg.poc_sync && !r_reg.poc_meta |=> !sys_reset_n_o [*4];
    endproperty
    a_wd2_hold: assert property (p_wd2_hold)
        else $error("watchdog-2 reset too short");

    property p_settle_first;
        $rose(sys_reset_n_o) && reset_cause_o != CAUSE_WDOG1 |->
            !cpu_run_o && clk_ctl_o.main_osc_en && !clk_ctl_o.sys_clk_en;
    endproperty
    a_settle_first: assert property (p_settle_first)
        else $error("CPU released without settle wait");

    property p_poc_hold;
        r_reg.poc_sync |=> !sys_reset_n_o && reset_cause_o == CAUSE_POC && ram_undef_o;
    endproperty
    a_poc_hold: assert property (p_poc_hold)
        else $error("power-on-clear did not hold reset");

    property p_cold_clocks;
        !sys_reset_n_o && reset_cause_o != CAUSE_WDOG1 |->
            !clk_ctl_o.main_osc_en && !clk_ctl_o.int_osc_en && !clk_ctl_o.wdog1_clk_en &&
            !clk_ctl_o.cpu_clk_en && clk_ctl_o.sub_osc_en;
    endproperty
    a_cold_clocks: assert property (p_cold_clocks)
        else $error("wrong clock state in cold reset");

    property p_run_start;
        $rose(cpu_run_o) |-> clk_ctl_o.sys_clk_en && clk_ctl_o.periph_clk_en &&
            $past(clk_ctl_o.clkdiv_init, 1) == 1'b0 || reset_cause_o == CAUSE_WDOG1;
    endproperty
    a_run_start: assert property (p_run_start)
        else $error("clocks not started with CPU");

endmodule
`default_nettype wire

// ==== wrs_req_model.sv ====
// Purpose: far-side model: watchdog-1, watchdog-2 overflow requests and power-on-clear level
// Assumes: requests launch 1 ns after a rising edge of core_clk_i
// Notes:   a watchdog request stays high for the number of cycles given to fire
`timescale 1ns/1ps
`default_nettype none

module wrs_req_model (
    input  wire logic core_clk_i,
    output var logic  wdog1_overflow_reset_o,
    output var logic  wdog2_overflow_reset_o,
    output var logic  power_on_clear_reset_o
);
    int   n1 = 0;
    int   n2 = 0;
    logic go1;
    logic go2;

    initial begin
        wdog1_overflow_reset_o = 1'b0;
        wdog2_overflow_reset_o = 1'b0;
        power_on_clear_reset_o = 1'b0;
    end

    // ------------------------------------------------------------------------
    // request control
    // ------------------------------------------------------------------------
    task automatic fire(input int which, input int len);
        if (which == 1) n1 = len;
        else n2 = len;
    endtask

    // the detector level is asynchronous and may move at any time
    task automatic set_poc(input logic v);
        power_on_clear_reset_o = v;
    endtask

    // counts are taken at the edge, well apart from the bench's own 1 ns step
    always @(posedge core_clk_i) begin
        go1 = (n1 > 0);
        go2 = (n2 > 0);
        if (n1 > 0) n1--;
        if (n2 > 0) n2--;
        #1;
        wdog1_overflow_reset_o = go1;
        wdog2_overflow_reset_o = go2;
    end
endmodule

`default_nettype wire

// ==== test_watchdog_and_poc_reset_sequencer.sv ====
// Purpose: self-checking bench of the watchdog and power-on-clear reset sequencer
// Assumes: settle shortened to 2 ** (2 + 1) cycles through the parameters
// Notes:   inputs move 1 ns after the rising edge; outputs are read there too
`timescale 1ns/1ps
`default_nettype none
`include "wrs_defs.svh"

module test_watchdog_and_poc_reset_sequencer;
    import wrs_pkg::*;
    localparam int BASE = 2;
    localparam int SEL  = 1;
    localparam int N    = 1 << (BASE + SEL);

    logic         core_clk_i   = 1'b0;
    logic         rstn_i       = 1'b0;
    logic         wdog1_mode_i = 1'b0;
    logic         wdog2_mode_i = 1'b0;
    logic         ram_write_i  = 1'b0;
    logic         w1_req;
    logic         w2_req;
    logic         poc_req;
    logic         sys_reset_n_o;
    logic         cpu_run_o;
    logic         ram_undef_o;
    wrs_cause_t   reset_cause_o;
    wrs_clk_ctl_t clk_ctl_o;
    wrs_pin_ctl_t pin_ctl_o;
    int           n_fail = 0;
    int           samples_checked = 0;
    int           cycles = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    wrs_reset_seq #(.SETTLE_BASE_LOG2(BASE), .OSC_SETTLE_DEFAULT(SEL)) u_wrs_reset_seq (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wdog1_mode_i(wdog1_mode_i),
        .wdog1_overflow_reset_i(w1_req), .wdog2_mode_i(wdog2_mode_i),
        .wdog2_overflow_reset_i(w2_req), .power_on_clear_reset_i(poc_req),
        .ram_write_i(ram_write_i), .sys_reset_n_o(sys_reset_n_o), .cpu_run_o(cpu_run_o),
        .reset_cause_o(reset_cause_o), .ram_undef_o(ram_undef_o),
        .clk_ctl_o(clk_ctl_o), .pin_ctl_o(pin_ctl_o));

    wrs_req_model u_wrs_req_model (
        .core_clk_i(core_clk_i), .wdog1_overflow_reset_o(w1_req),
        .wdog2_overflow_reset_o(w2_req), .power_on_clear_reset_o(poc_req));

    // ------------------------------------------------------------------------
    // expectations: 0 running, 1 watchdog-1 reset, 2 full reset
    // ------------------------------------------------------------------------
    function automatic wrs_clk_ctl_t exp_clk(input int ph);
        if (ph == 1) return 9'h1EE;
        if (ph == 2) return 9'h042;
        return 9'h1FD;
    endfunction

    function automatic int exp_hold(input int which);
        return (which == 1) ? 12 : `WRS_WDOG2_HOLD_CYC;
    endfunction

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic tick;
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic settle_phase(input string name);
        int m;
        m = 0;
        check(cpu_run_o, 1'b0, "cpu held in settle");
        check({clk_ctl_o.main_osc_en, clk_ctl_o.sys_clk_en, clk_ctl_o.cpu_clk_en,
               clk_ctl_o.periph_clk_en}, 4'h8, "settle clocks");
        while (cpu_run_o !== 1'b1 && m < 300) begin
            tick();
            m++;
        end
        check(m >= N && m <= N + 4, 1'b1, "settle length");
        check(clk_ctl_o, exp_clk(0), "clocks after settle");
        check(pin_ctl_o, 3'h0, "pins after settle");
        $display("test %s done", name);
    endtask

    task automatic run_wdog(input int which, input logic mode, input int len);
        logic r;
        int   n;
        r = 1'($urandom % 2);
        ram_write_i = r;
        if (which == 1) wdog1_mode_i = mode;
        else wdog2_mode_i = mode;
        u_wrs_req_model.fire(which, len);
        n = 0;
        while (sys_reset_n_o === 1'b1 && n < 20) begin
            tick();
            n++;
        end
        if (!mode) begin
            check(sys_reset_n_o, 1'b1, "request ignored with mode off");
            $display("test mode-off watchdog %0d done", which);
            return;
        end
        ram_write_i = 1'($urandom % 2);
        check(ram_undef_o, r, "ram flag");
        check(reset_cause_o, (which == 1) ? CAUSE_WDOG1 : CAUSE_WDOG2, "cause");
        check(clk_ctl_o, exp_clk(which == 1 ? 1 : 2), "clocks in reset");
        check(pin_ctl_o, 3'h3, "pins in reset");
        n = 0;
        while (sys_reset_n_o === 1'b0 && n < 300) begin
            tick();
            n++;
        end
        check(n, exp_hold(which), "hold length");
        if (which == 1) begin
            check(cpu_run_o, 1'b1, "cpu at release");
            check(clk_ctl_o, exp_clk(0), "clocks after release");
            $display("test watchdog-1 reset done");
        end else begin
            settle_phase("watchdog-2 reset");
        end
    endtask

    task automatic run_poc(input int len);
        int n;
        u_wrs_req_model.set_poc(1'b1);
        repeat (len) tick();
        check(sys_reset_n_o, 1'b0, "reset while poc high");
        check(reset_cause_o, CAUSE_POC, "poc cause");
        check(ram_undef_o, 1'b1, "ram undefined");
        check(clk_ctl_o, exp_clk(2), "clocks in poc");
        u_wrs_req_model.set_poc(1'b0);
        n = 0;
        while (sys_reset_n_o === 1'b0 && n < 20) begin
            tick();
            n++;
        end
        check(n >= 2 && n <= 4, 1'b1, "poc release delay");
        settle_phase("power-on-clear");
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        int k;
        void'($urandom(32'hdebf_fecc));
        repeat (16) @(posedge core_clk_i);
        #1;
        check(sys_reset_n_o, 1'b0, "reset during rstn");
        rstn_i = 1'b1;
        tick();
        check(ram_undef_o, 1'b1, "ram after power up");
        settle_phase("power up");
        run_wdog(1, 1'b1, 12);
        run_wdog(2, 1'b1, 1);
        run_wdog(1, 1'b0, 1);
        run_wdog(2, 1'b0, 1);
        run_poc(6);
        repeat (10) begin
            k = $urandom % 5;
            wdog1_mode_i = 1'($urandom % 2);
            wdog2_mode_i = 1'($urandom % 2);
            if (k == 0) run_wdog(1, 1'b1, 1 + $urandom % 12);
            else if (k == 1) run_wdog(2, 1'b1, 1);
            else if (k == 4) run_poc(4 + $urandom % 20);
            else run_wdog(k - 1, 1'b0, 1 + $urandom % 3);
            repeat ($urandom % 5) tick();
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
